//--- logic/aex_engine.sv
`timescale 1ns/1ps
module aex_engine
   import aex_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic deepest_low_power_state,
   input wire logic access_blocked,
   input wire aex_acc_s acc,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic op_done,
   output logic cipher_error
);
   aex_state_s q, n;

   function automatic logic [7:0] xt(input logic [7:0] a);
      return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
   endfunction

   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] x;
      p = 8'h00;
      x = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) p = p ^ x;
         x = xt(x);
      end
      return p;
   endfunction

   // multiplicative inverse as x^254, zero maps to zero
   function automatic logic [7:0] ginv(input logic [7:0] a);
      logic [7:0] p;
      logic [7:0] x;
      p = 8'h01;
      x = a;
      for (int i = 0; i < 7; i++) begin
         x = gmul(x, x);
         p = gmul(p, x);
      end
      return p;
   endfunction

   function automatic logic [7:0] rl(input logic [7:0] b, input int s);
      return 8'((b << s) | (b >> (8 - s)));
   endfunction

   function automatic logic [7:0] sbox(input logic [7:0] a);
      logic [7:0] b;
      b = ginv(a);
      return b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ 8'h63;
   endfunction

   function automatic logic [7:0] isbox(input logic [7:0] s);
      return ginv(rl(s, 1) ^ rl(s, 3) ^ rl(s, 6) ^ 8'h05);
   endfunction

   // byte i of a block is page address 0x84+i; column c holds bytes 4c..4c+3
   function automatic logic [127:0] subsh(input logic [127:0] s, input logic inv);
      logic [127:0] o;
      int src;
      o = '0;
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            src = inv ? r + 4 * ((c - r + 4) % 4) : r + 4 * ((c + r) % 4);
            o[8*(r+4*c) +: 8] = inv ? isbox(s[8*src +: 8]) : sbox(s[8*src +: 8]);
         end
      end
      return o;
   endfunction

   function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
      logic [127:0] o;
      logic [31:0] cf;
      o = '0;
      cf = inv ? 32'h0e0b0d09 : 32'h02030101;
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            for (int j = 0; j < 4; j++) begin
               o[8*(r+4*c) +: 8] = o[8*(r+4*c) +: 8]
                  ^ gmul(s[8*(j+4*c) +: 8], cf[8*(3-((j-r+4)%4)) +: 8]);
            end
         end
      end
      return o;
   endfunction

   // sub-rotated last word plus round constant
   function automatic logic [31:0] kmix(input logic [31:0] w, input logic [7:0] rc);
      return {sbox(w[7:0]), sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]) ^ rc};
   endfunction

   function automatic logic [127:0] knext(input logic [127:0] k, input logic [7:0] rc);
      logic [31:0] w0, w1, w2, w3;
      w0 = k[31:0] ^ kmix(k[127:96], rc);
      w1 = k[63:32] ^ w0;
      w2 = k[95:64] ^ w1;
      w3 = k[127:96] ^ w2;
      return {w3, w2, w1, w0};
   endfunction

   function automatic logic [127:0] kprev(input logic [127:0] k, input logic [7:0] rc);
      logic [31:0] w1, w2, w3;
      w3 = k[127:96] ^ k[95:64];
      w2 = k[95:64] ^ k[63:32];
      w1 = k[63:32] ^ k[31:0];
      return {w3, w2, w1, k[31:0] ^ kmix(w3, rc)};
   endfunction

   logic in_win;
   logic in_page;
   logic [3:0] pidx;
   logic [7:0] ctrl_rd;
   logic [127:0] nk;
   logic [127:0] blk_in;
   logic [127:0] t;

   assign in_win = acc.en && !access_blocked
      && acc.addr >= ADDR_STATUS && acc.addr <= ADDR_CTRL_COPY;
   assign in_page = in_win && acc.addr >= ADDR_PAGE_LO && acc.addr <= ADDR_PAGE_HI;
   assign pidx = 4'(acc.addr - ADDR_PAGE_LO);
   assign ctrl_rd = {1'b0, 1'b0, q.mode, q.dir, 3'h0};

   // next state: access decode, start, rounds
   always_comb begin
      n = q;
      n.rd_valid = 1'b0;
      nk = '0;
      t = '0;
      // a start takes its mode from the written byte, not from the stored field
      blk_in = (acc.wdata[CTRL_MODE_LSB +: 2] == MODE_CBC) ? q.blk ^ q.chain : q.blk;
      if (q.fsm == ST_RUN) begin
         if (q.run_enc) begin
            nk = knext(q.rkey, q.rcon);
            t = subsh(q.blk, 1'b0);
            if (q.round != LAST_ROUND) t = mix(t, 1'b0);
            n.blk = t ^ nk;
            n.rcon = xt(q.rcon);
         end else begin
            nk = kprev(q.rkey, q.rcon);
            t = subsh(q.blk, 1'b1) ^ nk;
            n.blk = (q.round != LAST_ROUND) ? mix(t, 1'b1) : t;
            n.rcon = (q.rcon == 8'h1b) ? 8'h80 : {1'b0, q.rcon[7:1]};
         end
         n.rkey = nk;
         n.round = q.round + 4'h1;
         if (q.round == LAST_ROUND) begin
            n.fsm = ST_IDLE;
            n.done = 1'b1;
            n.chain = n.blk;
         end
      end
      if (in_win) begin
         n.rd_valid = 1'b1;
         // old content goes out, so data page writes see the byte they replace; key page writes see the round key byte
         if (in_page) begin
            n.rd_data = (q.mode == MODE_KEY) ? q.rkey[8*pidx +: 8]
               : q.blk[8*pidx +: 8];
         end else if (acc.addr == ADDR_STATUS) begin
            n.rd_data = {q.err, 6'h00, q.done};
         end else begin
            n.rd_data = ctrl_rd;
         end
         if (acc.addr == ADDR_CTRL && q.fsm == ST_RUN) begin
            n.fsm = ST_IDLE;
            n.err = 1'b1;
         end else if (acc.we && (acc.addr == ADDR_CTRL || acc.addr == ADDR_CTRL_COPY)) begin
            if (q.fsm != ST_RUN) begin
               n.mode = acc.wdata[CTRL_MODE_LSB +: 2];
               n.dir = acc.wdata[CTRL_DIR_BIT];
               if (acc.wdata[CTRL_REQ_BIT]) begin
                  // start from the initial key every time
                  n.fsm = ST_RUN;
                  n.done = 1'b0;
                  n.err = 1'b0;
                  n.round = 4'h1;
                  n.run_enc = (acc.wdata[CTRL_DIR_BIT] == DIR_ENC)
                     || (acc.wdata[CTRL_MODE_LSB +: 2] != MODE_ECB);
                  n.rcon = n.run_enc ? RCON_FIRST : RCON_LAST;
                  n.rkey = q.ikey;
                  n.blk = blk_in ^ q.ikey;
               end
            end
         end else if (acc.we && in_page && q.fsm != ST_RUN) begin
            if (q.mode == MODE_KEY) n.ikey[8*pidx +: 8] = acc.wdata;
            else n.blk[8*pidx +: 8] = acc.wdata;
         end
         // short read of the data page, after the start so that the set wins
         if (in_page && !acc.we && q.mode != MODE_KEY) begin
            n.rdcnt = (q.rdcnt == PAGE_BYTES - 5'h1) ? 5'h0 : q.rdcnt + 5'h1;
         end else if (!in_page && q.rdcnt != 5'h0) begin
            n.rdcnt = 5'h0;
            n.err = 1'b1;
         end
      end
   end

   // state register, cleared by reset and deepest sleep
   always_ff @(posedge clk) begin
      if (sys_rst || deepest_low_power_state) begin
         q <= '{fsm: ST_IDLE, mode: MODE_RST, dir: DIR_ENC, ikey: BLOCK_RST,
            rkey: BLOCK_RST, blk: BLOCK_RST, chain: BLOCK_RST, round: 4'h0,
            rcon: RCON_FIRST, run_enc: 1'b1, done: 1'b0, err: 1'b0,
            rdcnt: 5'h0, rd_data: 8'h00, rd_valid: 1'b0};
      end else begin
         q <= n;
      end
   end

   assign rd_data = q.rd_data;
   assign rd_valid = q.rd_valid;
   assign op_done = q.done;
   assign cipher_error = q.err;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || deepest_low_power_state);

   // cycles spent in the current run
   logic [9:0] run_cnt;
   always_ff @(posedge clk) begin
      if (sys_rst || q.fsm != ST_RUN) run_cnt <= 10'h0;
      else run_cnt <= run_cnt + 10'h1;
   end

   // run length, completion and start
   run_time_bound_a: assert property (run_cnt <= 10'(RUN_MAX_CYC))
      else $error("operation exceeds time bound");
   // a control byte access ends the run early, so it cancels the attempt
   run_ten_rounds_a: assert property (disable iff (sys_rst || deepest_low_power_state
      || (in_win && acc.addr == ADDR_CTRL))
      $rose(q.fsm == ST_RUN) && !in_win |-> (q.fsm == ST_RUN) [*8] ##3 op_done)
      else $error("run does not finish in ten rounds");
   start_clear_a: assert property ($rose(q.fsm == ST_RUN) |-> !op_done)
      else $error("done still set at run start");
   dec_ecb_only_a: assert property ($rose(q.fsm == ST_RUN) && !q.run_enc
      |-> q.mode == MODE_ECB)
      else $error("decryption started outside block mode");
   start_key_a: assert property ($rose(q.fsm == ST_RUN) |-> q.rkey == $past(q.ikey))
      else $error("run did not start from initial key");
   ctrl_abort_a: assert property (q.fsm == ST_RUN && in_win && acc.addr == ADDR_CTRL
      |=> q.fsm == ST_IDLE && cipher_error)
      else $error("control access did not abort");
   mirror_start_a: assert property (q.fsm == ST_IDLE && in_win && acc.we
      && acc.addr == ADDR_CTRL_COPY && acc.wdata[CTRL_REQ_BIT] |=> q.fsm == ST_RUN)
      else $error("mirror request did not start");
   copy_mode_a: assert property (q.fsm == ST_IDLE && in_win && acc.we
      && acc.addr == ADDR_CTRL_COPY |=> q.mode == $past(acc.wdata[CTRL_MODE_LSB +: 2]))
      else $error("mirror write did not set mode");

   // key storage and page selection
   ikey_stable_a: assert property (q.fsm == ST_RUN |=> $stable(q.ikey))
      else $error("initial key changed during run");
   key_page_read_a: assert property (in_page && !acc.we && q.mode == MODE_KEY
      |=> rd_data == $past(q.rkey[8*pidx +: 8]))
      else $error("key page read wrong source");
   lag_read_a: assert property (in_page && q.mode != MODE_KEY && q.fsm == ST_IDLE
      |=> rd_valid && rd_data == $past(q.blk[8*pidx +: 8]))
      else $error("fast access byte mismatch");

   // access answers and error flag
   blocked_quiet_a: assert property (access_blocked |=> !rd_valid)
      else $error("access answered while blocked");
   status_read_a: assert property (in_win && acc.addr == ADDR_STATUS
      |=> rd_data == {$past(cipher_error), 6'h00, $past(op_done)})
      else $error("status byte wrong");
   short_read_a: assert property (in_win && !in_page && q.rdcnt != 5'h0
      |=> cipher_error)
      else $error("short page read not flagged");

   // main scenarios
   enc_run_c: cover property ($fell(q.fsm == ST_RUN) && q.run_enc && op_done);
   dec_run_c: cover property ($fell(q.fsm == ST_RUN) && !q.run_enc && op_done);
   cbc_run_c: cover property ($rose(q.fsm == ST_RUN) && q.mode == MODE_CBC);
   abort_c: cover property (q.fsm == ST_RUN && in_win && acc.addr == ADDR_CTRL);
   short_read_c: cover property (in_win && !in_page && q.rdcnt != 5'h0);
endmodule

//--- logic/aex_pkg.sv
package aex_pkg;
   // address window of the cipher block
   localparam logic [7:0] ADDR_STATUS = 8'h82;
   localparam logic [7:0] ADDR_CTRL = 8'h83;
   localparam logic [7:0] ADDR_PAGE_LO = 8'h84;
   localparam logic [7:0] ADDR_PAGE_HI = 8'h93;
   localparam logic [7:0] ADDR_CTRL_COPY = 8'h94;
   // control byte fields
   localparam int CTRL_REQ_BIT = 7;
   localparam int CTRL_MODE_LSB = 4;
   localparam int CTRL_DIR_BIT = 3;
   // status byte fields
   localparam int STAT_ERR_BIT = 7;
   localparam int STAT_DONE_BIT = 0;
   // mode and direction codes
   localparam logic [1:0] MODE_ECB = 2'h0;
   localparam logic [1:0] MODE_KEY = 2'h1;
   localparam logic [1:0] MODE_CBC = 2'h2;
   localparam logic DIR_ENC = 1'b0;
   // reset values
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [127:0] BLOCK_RST = 128'h0;
   // round and page figures
   localparam logic [3:0] LAST_ROUND = 4'ha;
   localparam logic [7:0] RCON_FIRST = 8'h01;
   localparam logic [7:0] RCON_LAST = 8'h36;
   localparam logic [4:0] PAGE_BYTES = 5'h10;
   // timing
   localparam int CLK_MHZ = 20;
   localparam int RUN_MAX_US = 24;
   localparam int RUN_MAX_CYC = RUN_MAX_US * CLK_MHZ;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } aex_fsm_e;

   // one SRAM-style byte access
   typedef struct packed {
      logic en;
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } aex_acc_s;

   typedef struct packed {
      aex_fsm_e fsm;
      logic [1:0] mode;
      logic dir;
      logic [127:0] ikey;
      logic [127:0] rkey;
      logic [127:0] blk;
      logic [127:0] chain;
      logic [3:0] round;
      logic [7:0] rcon;
      logic run_enc;
      logic done;
      logic err;
      logic [4:0] rdcnt;
      logic [7:0] rd_data;
      logic rd_valid;
   } aex_state_s;
endpackage

//--- sim/aes128_ecb_cbc_engine_tb.sv
`timescale 1ns/1ps
module aes128_ecb_cbc_engine_tb
   import aex_pkg::*;
;
   localparam logic [127:0] K = 128'h000102030405060708090a0b0c0d0e0f;
   localparam logic [127:0] P = 128'h00112233445566778899aabbccddeeff;
   localparam logic [127:0] C = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
   localparam logic [127:0] L = 128'h13111d7fe3944a17f307a78b4d2b30c5;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic dlps = 1'b0;
   logic blocked = 1'b0;
   aex_acc_s acc;
   logic [7:0] rd_data;
   logic rd_valid;
   logic op_done;
   logic cipher_error;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;
   aex_engine aex_engine_i (.clk(clk), .sys_rst(sys_rst), .deepest_low_power_state(dlps),
      .access_blocked(blocked), .acc(acc), .rd_data(rd_data), .rd_valid(rd_valid),
      .op_done(op_done), .cipher_error(cipher_error));
   aex_host aex_host_i (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .acc(acc));
   // 20 MHz clock
   always #25 clk = ~clk;
   // control byte and status byte as the host expects them
   function automatic logic [7:0] ctl(input logic [1:0] m, input logic d);
      return {2'b00, m, d, 3'b000};
   endfunction
   function automatic logic [7:0] stat(input logic e, input logic d);
      return {e, 6'b000000, d};
   endfunction
   task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wait_done();
      for (int n = 0; n < RUN_MAX_CYC && op_done !== 1'b1; n++) begin
         @(negedge clk);
      end
      chk("op_done", op_done, 1'b1);
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   // main sequence
   initial begin
      logic [127:0] o;
      logic [127:0] v;
      logic [127:0] r;
      logic [7:0] b;
      logic g;
      r = {96'h0, $urandom(13)};
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      aex_host_i.xfer(1'b0, ADDR_STATUS, 8'h00, b, g);
      chk("status after reset", b, stat(1'b0, 1'b0));
      chk("status answer", g, 1'b1);
      aex_host_i.burst(ctl(MODE_KEY, 1'b0), K, 1'b0, o);
      aex_host_i.burst(ctl(MODE_ECB, DIR_ENC), P, 1'b1, o);
      wait_done();
      aex_host_i.burst(ctl(MODE_CBC, DIR_ENC), P ^ C, 1'b1, o);
      chk("fast access out", o, C);
      wait_done();
      aex_host_i.rdpage(v);
      chk("cbc result", v, C);
      aex_host_i.xfer(1'b0, ADDR_STATUS, 8'h00, b, g);
      chk("status done", b, stat(1'b0, 1'b1));
      aex_host_i.xfer(1'b1, ADDR_CTRL, ctl(MODE_KEY, 1'b0), b, g);
      aex_host_i.rdpage(v);
      chk("last round key", v, L);
      aex_host_i.burst(ctl(MODE_ECB, DIR_ENC), P, 1'b1, o);
      wait_done();
      aex_host_i.rdpage(v);
      chk("initial key kept", v, C);
      for (int k = 0; k < 3; k++) begin
         r = {$urandom(), $urandom(), $urandom(), $urandom()};
         aex_host_i.burst(ctl(MODE_ECB, DIR_ENC), r, 1'b1, o);
         wait_done();
         aex_host_i.rdpage(v);
         aex_host_i.burst(ctl(MODE_KEY, 1'b0), L, 1'b0, o);
         aex_host_i.burst(ctl(MODE_ECB, 1'b1), v, 1'b0, o);
         aex_host_i.xfer(1'b1, ADDR_CTRL, ctl(MODE_ECB, 1'b1) | 8'h80, b, g);
         wait_done();
         aex_host_i.rdpage(v);
         chk("decrypt round trip", v, r);
         aex_host_i.burst(ctl(MODE_KEY, 1'b0), K, 1'b0, o);
      end
      aex_host_i.xfer(1'b1, ADDR_CTRL, ctl(MODE_ECB, DIR_ENC), b, g);
      for (int i = 0; i < 4; i++) begin
         aex_host_i.xfer(1'b0, ADDR_PAGE_LO + 8'(i), 8'h00, b, g);
      end
      aex_host_i.xfer(1'b0, ADDR_STATUS, 8'h00, b, g);
      chk("short read error", cipher_error, 1'b1);
      aex_host_i.burst(ctl(MODE_ECB, DIR_ENC), P, 1'b1, o);
      aex_host_i.xfer(1'b0, ADDR_CTRL, 8'h00, b, g);
      chk("abort error", cipher_error, 1'b1);
      repeat (20) @(posedge clk);
      chk("abort no done", op_done, 1'b0);
      for (int i = 0; i < 4; i++) begin
         b = (i == 0) ? 8'h95 : (i == 1) ? 8'h81 : 8'($urandom_range(8'h95, 8'hff));
         aex_host_i.xfer(1'b1, b, 8'h80, b, g);
         chk("out of window answer", g, 1'b0);
      end
      aex_host_i.xfer(1'b1, ADDR_CTRL, ctl(MODE_KEY, 1'b1), b, g);
      @(posedge clk);
      blocked <= 1'b1;
      aex_host_i.xfer(1'b0, ADDR_STATUS, 8'h00, b, g);
      chk("blocked answer", g, 1'b0);
      @(posedge clk);
      blocked <= 1'b0;
      dlps <= 1'b1;
      repeat (2) @(posedge clk);
      dlps <= 1'b0;
      aex_host_i.xfer(1'b0, ADDR_CTRL, 8'h00, b, g);
      chk("control cleared", b, ctl(MODE_RST, DIR_ENC));
      aex_host_i.xfer(1'b1, ADDR_CTRL, ctl(MODE_KEY, 1'b0), b, g);
      aex_host_i.rdpage(v);
      chk("keys cleared", v, BLOCK_RST);
      end_of_test();
   end
endmodule

//--- sim/aex_host.sv
`timescale 1ns/1ps
module aex_host
   import aex_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   output aex_acc_s acc
);
   initial acc = '0;
   // one byte access: request for one edge, answer one edge later
   task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] rd, output logic got);
      @(posedge clk);
      acc <= '{en: 1'b1, we: we, addr: a, wdata: d};
      @(posedge clk);
      acc.en <= 1'b0;
      acc.wdata <= ~d; // released data never shows the old byte
      #1;
      rd = rd_data;
      got = rd_valid;
   endtask
   // burst from the control byte, optional start at the copy
   task automatic burst(input logic [7:0] c, input logic [127:0] w, input logic go,
      output logic [127:0] old);
      logic [7:0] r;
      logic g;
      xfer(1'b1, ADDR_CTRL, c, r, g);
      for (int i = 0; i < 16; i++) begin
         xfer(1'b1, ADDR_PAGE_LO + 8'(i), w[127-8*i -: 8], r, g);
         old[127-8*i -: 8] = r;
      end
      if (go) begin
         xfer(1'b1, ADDR_CTRL_COPY, c | 8'h80, r, g);
      end
   endtask
   // full sixteen-byte page read
   task automatic rdpage(output logic [127:0] v);
      logic [7:0] r;
      logic g;
      for (int i = 0; i < 16; i++) begin
         xfer(1'b0, ADDR_PAGE_LO + 8'(i), 8'h00, r, g);
         v[127-8*i -: 8] = r;
      end
   endtask
endmodule
